// file: cffm_defines.svh
// register offsets, field positions and timing constants for the fault flag / mask block
`ifndef CFFM_DEFINES_SVH
`define CFFM_DEFINES_SVH

// ==========================================================
// register offsets
`define CFFM_OFS_FLAGS_FIRST   8'h26
`define CFFM_OFS_FLAGS_SECOND  8'h27
`define CFFM_OFS_MASK_FIRST    8'h28

// ==========================================================
// fault_flags_second fields
`define CFFM_F2_SYS_SHORT      7
`define CFFM_F2_SYS_OVP        6
`define CFFM_F2_SRC_OVP        5
`define CFFM_F2_SRC_UVP        4
`define CFFM_F2_OVERHEAT       2
`define CFFM_F2_LIVE_BITS      8'hf4

// ==========================================================
// fault_flags_first fields
`define CFFM_F1_IN_B_OVP       1
`define CFFM_F1_IN_A_OVP       0

// ==========================================================
// mask fields
`define CFFM_M_ICUR            7
`define CFFM_M_IVOLT           6
`define CFFM_M_TIMEOUT         5
`define CFFM_M_WEAK            4
`define CFFM_M_PGOOD           3
`define CFFM_M_IN_B            2
`define CFFM_M_IN_A            1
`define CFFM_M_BUS             0
`define CFFM_NUM_IRQ_EVENTS    8

// ==========================================================
// reset values and pulse width
`define CFFM_RST_BYTE          8'h00
`define CFFM_IRQ_PULSE_NS      256
`define CFFM_CLK_PERIOD_NS     100
`define CFFM_IRQ_PULSE_CYC     ((`CFFM_IRQ_PULSE_NS + `CFFM_CLK_PERIOD_NS - 1) / `CFFM_CLK_PERIOD_NS)
`define CFFM_PCNT_W            4

`endif

// file: cffm_pkg.sv
// types shared by the fault flag / mask block
package cffm_pkg;
   typedef enum logic [1:0] {
      CFFM_IRQ_IDLE,
      CFFM_IRQ_PULSE
   } cffm_irq_state_t;
endpackage : cffm_pkg

// file: cffm_irq_pulse.sv
// fixed-width interrupt pulse generator
`timescale 1ns/1ps
`include "cffm_defines.svh"

module cffm_irq_pulse (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic nrst_i,
   // trigger and pulse
   input  wire logic trigger_i,
   output logic      irq_pulse_o
);

   // ==========================================================
   // pulse state
   cffm_pkg::cffm_irq_state_t     state;
   logic [`CFFM_PCNT_W-1:0]       count;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= cffm_pkg::CFFM_IRQ_IDLE;
         count <= '0;
      end else begin
         case (state)
            cffm_pkg::CFFM_IRQ_IDLE: begin
               if (trigger_i) begin
                  state <= cffm_pkg::CFFM_IRQ_PULSE;
                  count <= `CFFM_PCNT_W'(`CFFM_IRQ_PULSE_CYC - 1);
               end
            end
            cffm_pkg::CFFM_IRQ_PULSE: begin
               // events during a pulse merge into it; host reads flags anyway
               if (count == '0) begin
                  state <= cffm_pkg::CFFM_IRQ_IDLE;
               end else begin
                  count <= count - `CFFM_PCNT_W'(1);
               end
            end
            default: begin
               state <= cffm_pkg::CFFM_IRQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_pulse_o <= 1'b0;
      end else begin
         irq_pulse_o <= (state == cffm_pkg::CFFM_IRQ_IDLE) ? trigger_i
                        : (count != '0);
      end
   end

endmodule : cffm_irq_pulse

// file: cffm_fault_flags.sv
// fault flag registers, event mask register and interrupt pulse logic
`timescale 1ns/1ps
`include "cffm_defines.svh"

// Overview of operation
// RQ1 - system short halt sets flag bit 7; reads 0 after power-on
// RQ2 - system overvoltage halt sets flag bit 6; reads 0 after power-on
// RQ3 - source mode stop on bus overvoltage sets flag bit 5
// RQ4 - source mode stop on bus undervoltage sets flag bit 4
// RQ5 - overheat sets flag bit 2; bits 3, 1, 0 read zero
// RQ6 - current regulation entry pulses interrupt unless mask bit 7 set
// RQ7 - voltage regulation entry pulses interrupt unless mask bit 6 set
// RQ8 - host watchdog expiry pulses interrupt unless mask bit 5 set
// RQ9 - weak source detection interrupts unless mask bit 4 set
// RQ10 - power-good toggle interrupts unless mask bit 3 set
// RQ11 - input b presence change interrupts unless mask bit 2 set
// RQ12 - input a presence change interrupts unless mask bit 1 set
// RQ13 - bus presence change interrupts unless mask bit 0; register reset clears mask
// RQ14 - flags stay latched until the host reads their register
// RQ15 - host reads flags after a pulse and writes mask to choose events
module cffm_fault_flags (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       nrst_i,
   // register access from the serial host interface
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       reg_reset_cmd_i,
   // fault events, one-cycle pulses
   input  wire logic       system_rail_short_event_i,
   input  wire logic       system_rail_overvoltage_event_i,
   input  wire logic       source_mode_overvoltage_event_i,
   input  wire logic       source_mode_undervoltage_event_i,
   input  wire logic       die_overheat_event_i,
   input  wire logic       input_b_overvoltage_event_i,
   input  wire logic       input_a_overvoltage_event_i,
   // interrupt sources
   input  wire logic       current_limit_entry_i,
   input  wire logic       voltage_limit_entry_i,
   input  wire logic       host_timeout_i,
   input  wire logic       weak_source_i,
   input  wire logic       power_good_i,
   input  wire logic       input_b_present_i,
   input  wire logic       input_a_present_i,
   input  wire logic       bus_present_i,
   // interrupt
   output logic            irq_pulse_o
);

   // ==========================================================
   // registers
   logic [7:0] fault_flags_first;
   logic [7:0] fault_flags_second;
   logic [7:0] event_interrupt_mask_first;
   logic [7:0] next_fault_flags_first;
   logic [7:0] next_fault_flags_second;
   logic [7:0] f2_set;
   logic [7:0] f1_set;
   logic       rd_f1;
   logic       rd_f2;
   logic       wr_mask;
   logic [7:0] next_reg_rdata;

   // ==========================================================
   // access decode
   assign rd_f1   = reg_rd_i && (reg_addr_i == `CFFM_OFS_FLAGS_FIRST);
   assign rd_f2   = reg_rd_i && (reg_addr_i == `CFFM_OFS_FLAGS_SECOND);
   assign wr_mask = reg_wr_i && (reg_addr_i == `CFFM_OFS_MASK_FIRST);

   // ==========================================================
   // flag set vectors, one bit per fault event
   always_comb begin
      f2_set = `CFFM_RST_BYTE;
      f2_set[`CFFM_F2_SYS_SHORT] = system_rail_short_event_i;        // RQ1
      f2_set[`CFFM_F2_SYS_OVP]   = system_rail_overvoltage_event_i;  // RQ2
      f2_set[`CFFM_F2_SRC_OVP]   = source_mode_overvoltage_event_i;  // RQ3
      f2_set[`CFFM_F2_SRC_UVP]   = source_mode_undervoltage_event_i; // RQ4
      f2_set[`CFFM_F2_OVERHEAT]  = die_overheat_event_i;             // RQ5
      f1_set = `CFFM_RST_BYTE;
      f1_set[`CFFM_F1_IN_B_OVP]  = input_b_overvoltage_event_i;
      f1_set[`CFFM_F1_IN_A_OVP]  = input_a_overvoltage_event_i;
   end

   // ==========================================================
   // flag latching
   // read clears, but an event in the same cycle survives the clear
   always_comb begin
      next_fault_flags_second = fault_flags_second;
      if (rd_f2) begin
         next_fault_flags_second = `CFFM_RST_BYTE;                  // RQ14
      end
      next_fault_flags_second = next_fault_flags_second | f2_set;   // RQ14
      next_fault_flags_second = next_fault_flags_second & `CFFM_F2_LIVE_BITS; // RQ5
   end

   always_comb begin
      next_fault_flags_first = fault_flags_first;
      if (rd_f1) begin
         next_fault_flags_first = `CFFM_RST_BYTE;
      end
      next_fault_flags_first = next_fault_flags_first | f1_set;     // RQ14
   end

   // ==========================================================
   // flags are power-on only; the register-reset command leaves them alone
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_flags_first  <= `CFFM_RST_BYTE;
         fault_flags_second <= `CFFM_RST_BYTE;                       // RQ1 RQ2
      end else begin
         fault_flags_first  <= next_fault_flags_first;
         fault_flags_second <= next_fault_flags_second;
      end
   end

   // ==========================================================
   // event mask; the reset command beats a write in the same cycle
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         event_interrupt_mask_first <= `CFFM_RST_BYTE;
      end else if (reg_reset_cmd_i) begin
         event_interrupt_mask_first <= `CFFM_RST_BYTE;               // RQ13
      end else if (wr_mask) begin
         event_interrupt_mask_first <= reg_wdata_i;                  // RQ15
      end
   end

   // ==========================================================
   // read data; unmapped offsets read as zero
   always_comb begin
      case (reg_addr_i)
         `CFFM_OFS_FLAGS_FIRST:  next_reg_rdata = fault_flags_first;
         `CFFM_OFS_FLAGS_SECOND: next_reg_rdata = fault_flags_second;
         `CFFM_OFS_MASK_FIRST:   next_reg_rdata = event_interrupt_mask_first;
         default:                next_reg_rdata = `CFFM_RST_BYTE;
      endcase
   end

   // held until the next read, so the host may fetch it late
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= `CFFM_RST_BYTE;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_reg_rdata;
      end
   end

   // ==========================================================
   // change detection on status levels
   logic [2:0] status_now;
   logic [2:0] status_prev;
   logic [2:0] status_change;
   logic       status_seen;

   assign status_now = {input_b_present_i, input_a_present_i, bus_present_i};

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_prev <= '0;
         status_seen <= 1'b0;
      end else begin
         status_prev <= status_now;
         status_seen <= 1'b1;
      end
   end

   // ==========================================================
   // power-good history, seeded like the presence levels
   logic       pgood_prev;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pgood_prev <= 1'b0;
      end else begin
         pgood_prev <= power_good_i;
      end
   end

   // first cycle after reset only seeds history, so no false change pulse
   always_comb begin
      status_change = '0;
      if (status_seen) begin
         status_change = status_now ^ status_prev;
      end
   end

   // ==========================================================
   // masked interrupt sources, one per mask bit
   logic [`CFFM_NUM_IRQ_EVENTS-1:0] irq_event;
   logic [`CFFM_NUM_IRQ_EVENTS-1:0] irq_pass;
   logic                            irq_trigger;

   always_comb begin
      irq_event = `CFFM_RST_BYTE;
      irq_event[`CFFM_M_ICUR]    = current_limit_entry_i;                   // RQ6
      irq_event[`CFFM_M_IVOLT]   = voltage_limit_entry_i;                   // RQ7
      irq_event[`CFFM_M_TIMEOUT] = host_timeout_i;                          // RQ8
      irq_event[`CFFM_M_WEAK]    = weak_source_i;                           // RQ9
      irq_event[`CFFM_M_PGOOD]   = status_seen && (power_good_i != pgood_prev); // RQ10
      irq_event[`CFFM_M_IN_B]    = status_change[2];                        // RQ11
      irq_event[`CFFM_M_IN_A]    = status_change[1];                        // RQ12
      irq_event[`CFFM_M_BUS]     = status_change[0];                        // RQ13
   end

   genvar gi;
   generate
      for (gi = 0; gi < `CFFM_NUM_IRQ_EVENTS; gi++) begin : g_mask
         assign irq_pass[gi] = irq_event[gi] & ~event_interrupt_mask_first[gi]; // RQ6
      end
   endgenerate

   assign irq_trigger = |irq_pass;

   // ==========================================================
   // interrupt pulse
   cffm_irq_pulse cffm_irq_pulse_i (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .trigger_i   (irq_trigger),
      .irq_pulse_o (irq_pulse_o)
   );

endmodule : cffm_fault_flags

// file: cffm_props.sv
// concurrent checks on the fault flag and mask block ports
`timescale 1ns/1ps
// ==========================================================
module cffm_props (
   // clock and reset
   input wire logic       sys_clk_i,
   input wire logic       nrst_i,
   // register access
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       reg_reset_cmd_i,
   // fault events
   input wire logic       system_rail_short_event_i,
   input wire logic       system_rail_overvoltage_event_i,
   input wire logic       source_mode_overvoltage_event_i,
   input wire logic       source_mode_undervoltage_event_i,
   input wire logic       die_overheat_event_i,
   // interrupt sources and pulse
   input wire logic       current_limit_entry_i,
   input wire logic       voltage_limit_entry_i,
   input wire logic       host_timeout_i,
   input wire logic       weak_source_i,
   input wire logic       power_good_i,
   input wire logic       input_b_present_i,
   input wire logic       input_a_present_i,
   input wire logic       bus_present_i,
   input wire logic       irq_pulse_o
);
   logic [7:0] mask_q;
   logic [3:0] lvl_q;
   logic       cause_q;
   wire  [4:0] f2_ev = {system_rail_short_event_i, system_rail_overvoltage_event_i,
      source_mode_overvoltage_event_i, source_mode_undervoltage_event_i, die_overheat_event_i};
   wire  [7:0] src = {current_limit_entry_i, voltage_limit_entry_i, host_timeout_i,
      weak_source_i, power_good_i, input_b_present_i, input_a_present_i, bus_present_i};
   // lvl_q starts at 0, so a seeded level only loosens the cause check
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_q  <= 8'h00;
         lvl_q   <= 4'h0;
         cause_q <= 1'b0;
      end else begin
         if (reg_reset_cmd_i) begin
            mask_q <= 8'h00;
         end else if (reg_wr_i && reg_addr_i == 8'h28) begin
            mask_q <= reg_wdata_i;
         end
         lvl_q   <= src[3:0];
         cause_q <= |((src ^ {4'h0, lvl_q}) & ~mask_q);
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_rd27;
      reg_rd_i && reg_addr_i == 8'h27;
   endsequence
   sequence s_rd27_quiet;
      reg_rd_i && reg_addr_i == 8'h27 && !(|f2_ev);
   endsequence
   property p_flag(logic ev, int b);
      ev ##1 !reg_rd_i ##1 s_rd27 |=> reg_rdata_o[b];
   endproperty
   AST_FLAG_SHORT: assert property (p_flag(system_rail_short_event_i, 7))
      else $error("short flag missing on read");
   AST_FLAG_HEAT: assert property (p_flag(die_overheat_event_i, 2))
      else $error("overheat flag missing on read");
   AST_RSVD_ZERO: assert property (s_rd27 |=> reg_rdata_o[3] == 1'b0 && reg_rdata_o[1:0] == 2'h0)
      else $error("reserved flag bits not zero");
   AST_READ_CLEAR: assert property (s_rd27_quiet ##1 !(|f2_ev) ##1 s_rd27_quiet |=> (reg_rdata_o & 8'hf4) == 8'h00)
      else $error("flag survived its read");
   AST_MASK_READ: assert property (reg_rd_i && reg_addr_i == 8'h28 && !reg_wr_i && !reg_reset_cmd_i |=> reg_rdata_o == mask_q)
      else $error("mask readback wrong");
   AST_IRQ_CAUSE: assert property ($rose(irq_pulse_o) |-> cause_q)
      else $error("pulse without unmasked cause");
   AST_IRQ_WIDTH: assert property ($rose(irq_pulse_o) |-> irq_pulse_o[*3] ##1 !irq_pulse_o)
      else $error("pulse width not three cycles");
   AST_IRQ_CURR: assert property (current_limit_entry_i && !mask_q[7] && !irq_pulse_o |=> irq_pulse_o)
      else $error("unmasked current event gave no pulse");
endmodule : cffm_props

bind cffm_fault_flags cffm_props cffm_props_i (.sys_clk_i, .nrst_i, .reg_wr_i, .reg_rd_i,
   .reg_reset_cmd_i, .irq_pulse_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
   .system_rail_short_event_i, .system_rail_overvoltage_event_i,
   .source_mode_overvoltage_event_i, .source_mode_undervoltage_event_i, .die_overheat_event_i,
   .current_limit_entry_i, .voltage_limit_entry_i, .host_timeout_i, .weak_source_i,
   .power_good_i, .input_b_present_i, .input_a_present_i, .bus_present_i);

// file: cffm_host.sv
// host processor model issuing register reads and writes
`timescale 1ns/1ps
module cffm_host (
   // clock
   input  wire logic       sys_clk_i,
   // register access
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   initial begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_wdata_o = 8'h00;
   end
   // strobes drop on the edge that takes them, so each access is one pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_o   <= 1'b0;
      @(negedge sys_clk_i);
      d = reg_rdata_i;
   endtask : rd
endmodule : cffm_host

// file: tb_top.sv
// self-checking bench for the fault flag and mask block
`timescale 1ns/1ps
module tb_top;
   logic       sys_clk_i;
   logic       nrst_i;
   logic       reg_reset_cmd_i;
   logic [6:0] ev;
   logic [7:0] src;
   logic [7:0] addr, wdata, rdata, rv;
   logic       wr, rd, irq;
   int         bad_count;
   int         checks;
   logic [7:0] flag_bit [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
   // ==========================================================
   cffm_host cffm_host_i (.sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
   cffm_fault_flags cffm_fault_flags_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_reset_cmd_i(reg_reset_cmd_i),
      .system_rail_short_event_i(ev[0]), .system_rail_overvoltage_event_i(ev[1]),
      .source_mode_overvoltage_event_i(ev[2]), .source_mode_undervoltage_event_i(ev[3]),
      .die_overheat_event_i(ev[4]), .input_b_overvoltage_event_i(ev[5]),
      .input_a_overvoltage_event_i(ev[6]), .current_limit_entry_i(src[7]),
      .voltage_limit_entry_i(src[6]), .host_timeout_i(src[5]), .weak_source_i(src[4]),
      .power_good_i(src[3]), .input_b_present_i(src[2]), .input_a_present_i(src[1]),
      .bus_present_i(src[0]), .irq_pulse_o(irq));
   // ==========================================================
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      cffm_host_i.rd(a, rv);
      chk("register read", rv, exp);
   endtask : rdchk
   // levels toggle, pulse sources drop after one cycle
   task automatic irq_try(input int j, input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      cffm_host_i.wr(8'h28, mask);
      @(posedge sys_clk_i);
      src[j] <= ~src[j];
      @(posedge sys_clk_i);
      if (j > 3) src[j] <= 1'b0;
      for (int c = 0; c < 6; c++) begin
         @(negedge sys_clk_i);
         n = n + {7'h00, irq};
      end
      chk("interrupt pulse cycles", n, exp);
      rdchk(8'h28, mask);
   endtask : irq_try
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   // ==========================================================
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      bad_count++;
      conclude();
   end
   initial begin
      nrst_i = 1'b0;
      reg_reset_cmd_i = 1'b0;
      ev = 7'h00;
      src = 8'h00;
      repeat (3) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rdchk(8'h26, 8'h00);
      rdchk(8'h27, 8'h00);
      rdchk(8'h28, 8'h00);
      rdchk(8'h30, 8'h00);
      for (int k = 0; k < 7; k++) begin
         @(posedge sys_clk_i);
         ev[k] <= 1'b1;
         @(posedge sys_clk_i);
         ev[k] <= 1'b0;
         rdchk(k < 5 ? 8'h27 : 8'h26, flag_bit[k]);
         rdchk(k < 5 ? 8'h27 : 8'h26, 8'h00);
      end
      @(posedge sys_clk_i);
      ev <= 7'h1f;
      @(posedge sys_clk_i);
      ev <= 7'h00;
      cffm_host_i.wr(8'h27, 8'h00);
      rdchk(8'h27, 8'hf4);
      // event on the very edge that takes the read must survive its clear
      fork
         rdchk(8'h27, 8'h00);
         begin
            @(posedge sys_clk_i);
            ev[0] <= 1'b1;
            @(posedge sys_clk_i);
            ev[0] <= 1'b0;
         end
      join
      rdchk(8'h27, 8'h80);
      for (int j = 0; j < 8; j++) begin
         irq_try(j, 8'hff, 8'h00);
         irq_try(j, ~(8'h01 << j), 8'h03);
      end
      cffm_host_i.wr(8'h28, 8'hff);
      @(posedge sys_clk_i);
      ev[4] <= 1'b1;
      reg_reset_cmd_i <= 1'b1;
      @(posedge sys_clk_i);
      ev[4] <= 1'b0;
      reg_reset_cmd_i <= 1'b0;
      rdchk(8'h28, 8'h00);
      rdchk(8'h27, 8'h04);
      // reset command and mask write on one edge
      fork
         cffm_host_i.wr(8'h28, 8'h5a);
         begin
            @(posedge sys_clk_i);
            reg_reset_cmd_i <= 1'b1;
            @(posedge sys_clk_i);
            reg_reset_cmd_i <= 1'b0;
         end
      join
      rdchk(8'h28, 8'h00);
      // mid-run reset must wipe flags and mask alike
      @(posedge sys_clk_i);
      ev <= 7'h7f;
      @(posedge sys_clk_i);
      ev <= 7'h00;
      cffm_host_i.wr(8'h28, 8'h3c);
      @(posedge sys_clk_i);
      nrst_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rdchk(8'h26, 8'h00);
      rdchk(8'h27, 8'h00);
      rdchk(8'h28, 8'h00);
      conclude();
   end
endmodule : tb_top
